// *** hw/tbu_cfg.svh ***
/*
 * register offsets, field positions, reset values and widths of the timer time base.
 * assumes nothing of its surroundings; included by the package, the time base, the monitor and the testbench.
 */
`ifndef TBU_CFG_SVH
`define TBU_CFG_SVH

// register word offsets on the plain register port
`define TBU_OFS_CONTROL_ONE   4'h0
`define TBU_OFS_STATUS_FLAGS  4'h1
`define TBU_OFS_EVENT_GEN     4'h2
`define TBU_OFS_COUNT_VALUE   4'h3
`define TBU_OFS_PRESCALE      4'h4
`define TBU_OFS_RELOAD        4'h5
`define TBU_OFS_REPEAT        4'h6
`define TBU_OFS_IRQ_ENABLE    4'h7
`define TBU_OFS_IRQ_CLEAR     4'h8

// control_one fields
`define TBU_BIT_COUNTER_ENABLE 0
`define TBU_BIT_UPDATE_DISABLE 1
`define TBU_BIT_UPDATE_REQ_SEL 2
`define TBU_BIT_RELOAD_PRE_EN  7

// status and event fields
`define TBU_BIT_UPDATE_FLAG    0
`define TBU_BIT_UPDATE_GEN     0

// widths and reset values
`define TBU_CNT_WIDTH          32
`define TBU_PRE_WIDTH          16
`define TBU_REP_WIDTH          8
`define TBU_RELOAD_RESET       32'hffffffff

`endif

// *** hw/tbu_pkg.sv ***
/*
 * types shared by the timer time-base modules.
 * assumes tbu_cfg.svh sits on the include path.
 */
`include "tbu_cfg.svh"

package tbu_pkg;

    // a register port request, one cycle wide
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [3:0]  addr;
        logic [31:0] wdata;
    } tbu_req_s;

    // control_one register contents
    typedef struct packed {
        logic reload_preload_enable;
        logic update_request_select;
        logic update_disable;
        logic counter_enable;
    } tbu_ctrl_s;

endpackage

// *** hw/tbu_prescaler.sv ***
/*
 * buffered prescaler: divides the timer clock by the active ratio plus one.
 * assumes one clock, synchronous active-low reset; load strobe comes from the update event.
 */
`timescale 1ns/1ns
`default_nettype none

module tbu_prescaler #(
    parameter int PRE_WIDTH = 16
) (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    // control
    input  wire logic                 run,
    input  wire logic                 restart,
    input  wire logic                 load,
    input  wire logic [PRE_WIDTH-1:0] preload,
    // result
    output var  logic                 tick
);
    import tbu_pkg::*;

    logic [PRE_WIDTH-1:0] ratio;
    logic [PRE_WIDTH-1:0] count;

    // elaboration-time width check
    if (PRE_WIDTH < 1 || PRE_WIDTH > 16) begin : g_bad_width
        $error("prescaler width must lie between 1 and 16");
    end

    // active ratio is loaded only on an update event
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ratio <= '0;
        end else if (load) begin
            ratio <= preload;
        end
    end

    // prescale counter, restarted by any overflow or update
    always_ff @(posedge clk) begin
        if (!rst_n || restart) begin
            count <= '0;
        end else if (run) begin
            count <= (count == ratio) ? '0 : count + 1'b1;
        end
    end

    // one counter_clock tick per ratio+1 enabled cycles
    assign tick = run && (count == ratio);

endmodule

`default_nettype wire

// *** hw/tbu_time_base.sv ***
/*
 * time-base unit of an advanced timer, upcounting mode only.
 * assumes one 20 MHz clock, synchronous active-low reset and a plain register port
 * whose read data appear in the cycle after the read strobe.
 */
// Function
// - auto-reload counter, 32 bits wide, clocked from prescaler output
// - divide counter clock by 1 to 65536 with 16-bit prescaler
// - new prescaler value takes effect only at next update event
// - counter, reload and prescaler values readable and writable any time
// - reload value accesses go to preload; shadow holds active value
// - preload copies continuously when enable clear, else at update only
// - overflow raises update event unless update disable set
// - counter advances only while counter enable set
// - counting begins one clock after counter enable set
// - count 0 to reload value, wrap to 0, signal overflow
// - with repetition, update after repeat value plus one overflows
// - update generate bit raises update immediately
// - update disable suppresses all updates; prescaler shadow unchanged, reload shadow too unless enable clear
// - with updates disabled, overflow still restarts counter and prescaler
// - request select set: software update sets no flag or interrupt
// - update reloads repetition, reload shadow, prescaler; sets flag
// - interrupt request available on update events
`timescale 1ns/1ns
`default_nettype none

`include "tbu_cfg.svh"

module tbu_time_base #(
    parameter int CNT_WIDTH = `TBU_CNT_WIDTH,
    parameter int PRE_WIDTH = `TBU_PRE_WIDTH,
    parameter int REP_WIDTH = `TBU_REP_WIDTH
) (
    // clock and reset
    input  wire logic        SYS_CLK,
    input  wire logic        RESETN,
    // register port
    input  wire logic [3:0]  REG_ADDR,
    input  wire logic [31:0] REG_WDATA,
    input  wire logic        REG_WR,
    input  wire logic        REG_RD,
    output var  logic [31:0] REG_RDATA,
    // time-base events
    output var  logic        UPDATE_EVENT,
    output var  logic        OVERFLOW,
    output var  logic        IRQ
);
    import tbu_pkg::*;

    // elaboration-time parameter checks
    if (CNT_WIDTH < 2 || CNT_WIDTH > 32) begin : g_bad_cnt
        $error("counter width must lie between 2 and 32");
    end
    if (REP_WIDTH < 1 || REP_WIDTH > 16) begin : g_bad_rep
        $error("repetition width must lie between 1 and 16");
    end

    tbu_req_s              req;
    tbu_ctrl_s             ctrl;
    logic                  running;
    logic [CNT_WIDTH-1:0]  count_value;
    logic [PRE_WIDTH-1:0]  prescale_value;
    logic [CNT_WIDTH-1:0]  reload_value;
    logic [CNT_WIDTH-1:0]  reload_shadow;
    logic [REP_WIDTH-1:0]  repeat_count_value;
    logic [REP_WIDTH-1:0]  repeat_left;
    logic                  update_flag;
    logic                  irq_enable;
    logic                  counter_clock;
    logic                  wrap;
    logic                  soft_update;
    logic                  hw_update;
    logic                  update_event;
    logic                  set_flag;
    logic                  clear_flag;
    logic                  cnt_write;
    logic [31:0]           next_rdata;

    // bundle the register port
    assign req.wr    = REG_WR;
    assign req.rd    = REG_RD;
    assign req.addr  = REG_ADDR;
    assign req.wdata = REG_WDATA;

    // control_one register
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            ctrl <= '0;
        end else if (req.wr && req.addr == `TBU_OFS_CONTROL_ONE) begin
            ctrl.counter_enable        <= req.wdata[`TBU_BIT_COUNTER_ENABLE];
            ctrl.update_disable        <= req.wdata[`TBU_BIT_UPDATE_DISABLE];
            ctrl.update_request_select <= req.wdata[`TBU_BIT_UPDATE_REQ_SEL];
            ctrl.reload_preload_enable <= req.wdata[`TBU_BIT_RELOAD_PRE_EN];
        end
    end

    // enable takes effect one clock after it is written
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            running <= 1'b0;
        end else begin
            running <= ctrl.counter_enable;
        end
    end

    // preload registers written by software
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            prescale_value     <= '0;
            reload_value       <= CNT_WIDTH'(`TBU_RELOAD_RESET);
            repeat_count_value <= '0;
            irq_enable         <= 1'b0;
        end else if (req.wr) begin
            unique case (req.addr)
                `TBU_OFS_PRESCALE:   prescale_value     <= req.wdata[PRE_WIDTH-1:0];
                `TBU_OFS_RELOAD:     reload_value       <= req.wdata[CNT_WIDTH-1:0];
                `TBU_OFS_REPEAT:     repeat_count_value <= req.wdata[REP_WIDTH-1:0];
                `TBU_OFS_IRQ_ENABLE: irq_enable         <= req.wdata[`TBU_BIT_UPDATE_FLAG];
                default: ;
            endcase
        end
    end

    // prescaler: ratio buffered until update, factor is value plus one
    tbu_prescaler #(
        .PRE_WIDTH (PRE_WIDTH)
    ) u_prescaler (
        .clk     (SYS_CLK),
        .rst_n   (RESETN),
        .run     (running),
        .restart (wrap || soft_update),
        .load    (update_event),
        .preload (prescale_value),
        .tick    (counter_clock)
    );

    // overflow when the counter reaches the active reload value
    assign wrap        = counter_clock && (count_value == reload_shadow);
    assign soft_update = req.wr && req.addr == `TBU_OFS_EVENT_GEN
                         && req.wdata[`TBU_BIT_UPDATE_GEN];
    assign hw_update   = wrap && (repeat_left == '0);
    assign update_event = !ctrl.update_disable && (hw_update || soft_update);
    assign cnt_write   = req.wr && req.addr == `TBU_OFS_COUNT_VALUE;

    // main counter: up from 0 to reload, wrap to 0
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            count_value <= '0;
        end else if (cnt_write) begin
            count_value <= req.wdata[CNT_WIDTH-1:0];
        end else if (soft_update || wrap) begin
            count_value <= '0;
        end else if (counter_clock) begin
            count_value <= count_value + 1'b1;
        end
    end

    // repetition down-counter, reloaded on every update
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            repeat_left <= '0;
        end else if (update_event) begin
            repeat_left <= repeat_count_value;
        end else if (wrap && repeat_left != '0) begin
            repeat_left <= repeat_left - 1'b1;
        end
    end

    // reload shadow: continuous copy or copy on update
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            reload_shadow <= CNT_WIDTH'(`TBU_RELOAD_RESET);
        end else if (!ctrl.reload_preload_enable || update_event) begin
            reload_shadow <= reload_value;
        end
    end

    // update flag: set wins over a software clear in the same cycle
    assign set_flag   = update_event && !(soft_update && ctrl.update_request_select);
    assign clear_flag = (req.wr && req.addr == `TBU_OFS_STATUS_FLAGS
                         && !req.wdata[`TBU_BIT_UPDATE_FLAG])
                        || (req.wr && req.addr == `TBU_OFS_IRQ_CLEAR
                         && req.wdata[`TBU_BIT_UPDATE_FLAG]);
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            update_flag <= 1'b0;
        end else if (set_flag) begin
            update_flag <= 1'b1;
        end else if (clear_flag) begin
            update_flag <= 1'b0;
        end
    end

    // registered event outputs and interrupt level
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            UPDATE_EVENT <= 1'b0;
            OVERFLOW     <= 1'b0;
            IRQ          <= 1'b0;
        end else begin
            UPDATE_EVENT <= update_event;
            OVERFLOW     <= wrap;
            IRQ          <= irq_enable && (update_flag || set_flag);
        end
    end

    // read data mux
    always_comb begin
        next_rdata = '0;
        unique case (req.addr)
            `TBU_OFS_CONTROL_ONE: begin
                next_rdata[`TBU_BIT_COUNTER_ENABLE] = ctrl.counter_enable;
                next_rdata[`TBU_BIT_UPDATE_DISABLE] = ctrl.update_disable;
                next_rdata[`TBU_BIT_UPDATE_REQ_SEL] = ctrl.update_request_select;
                next_rdata[`TBU_BIT_RELOAD_PRE_EN]  = ctrl.reload_preload_enable;
            end
            `TBU_OFS_STATUS_FLAGS: next_rdata[`TBU_BIT_UPDATE_FLAG] = update_flag;
            `TBU_OFS_COUNT_VALUE:  next_rdata[CNT_WIDTH-1:0] = count_value;
            `TBU_OFS_PRESCALE:     next_rdata[PRE_WIDTH-1:0] = prescale_value;
            `TBU_OFS_RELOAD:       next_rdata[CNT_WIDTH-1:0] = reload_value;
            `TBU_OFS_REPEAT:       next_rdata[REP_WIDTH-1:0] = repeat_count_value;
            `TBU_OFS_IRQ_ENABLE:   next_rdata[`TBU_BIT_UPDATE_FLAG] = irq_enable;
            default:               next_rdata = '0;
        endcase
    end

    // read data appear the cycle after the strobe, zero otherwise
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            REG_RDATA <= '0;
        end else begin
            REG_RDATA <= req.rd ? next_rdata : 32'h0;
        end
    end

endmodule

`default_nettype wire

// *** verification/tbu_time_base_monitor.sv ***
/* port assertions and covers for the time base.
   assumes tbu_cfg.svh on the include path; bound to the top module below. */
`timescale 1ns/1ns
`default_nettype none
`include "tbu_cfg.svh"
module tbu_time_base_monitor (
    // clock, reset, register port and events
    input wire logic        SYS_CLK,
    input wire logic        RESETN,
    input wire logic [3:0]  REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic        REG_WR,
    input wire logic        REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic        UPDATE_EVENT,
    input wire logic        OVERFLOW,
    input wire logic        IRQ
);
    logic run_en, upd_off, req_sel, irq_en;
    // decoded writes that the assertions depend on
    wire  ctl_wr = REG_WR && (REG_ADDR == `TBU_OFS_CONTROL_ONE);
    wire  ien_wr = REG_WR && (REG_ADDR == `TBU_OFS_IRQ_ENABLE);
    wire  gen_wr = REG_WR && (REG_ADDR == `TBU_OFS_EVENT_GEN) && REG_WDATA[0];
    wire  st_clr = REG_WR && (REG_ADDR == `TBU_OFS_STATUS_FLAGS) && !REG_WDATA[0];
    wire  ic_clr = REG_WR && (REG_ADDR == `TBU_OFS_IRQ_CLEAR) && REG_WDATA[0];
    wire  clr_wr = st_clr || ic_clr || (ien_wr && !REG_WDATA[0]);
    wire  quiet  = req_sel && !run_en;
    // mirror of the control and enable bits
    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            {req_sel, upd_off, run_en, irq_en} <= 4'h0;
        end else begin
            if (ctl_wr) begin
                {req_sel, upd_off, run_en} <= REG_WDATA[2:0];
            end
            if (ien_wr) begin
                irq_en <= REG_WDATA[0];
            end
        end
    end
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    a_rdata_idle:
        assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0) else $error("stray read data");
    a_gen_update:
        assert property (gen_wr && !upd_off |=> ##[0:1] UPDATE_EVENT) else $error("no sw update");
    a_update_cause:
        assert property (UPDATE_EVENT |-> OVERFLOW || $past(gen_wr) || $past(gen_wr, 2))
            else $error("update without cause");
    a_update_disable_quiet:
        assert property (upd_off && $past(upd_off) && $past(upd_off, 2) && $past(upd_off, 3)
                         |-> !UPDATE_EVENT)
            else $error("update while disabled");
    a_ovf_gated:
        assert property (!run_en && !$past(run_en) && !$past(run_en, 2) && !$past(run_en, 3)
                         |-> !OVERFLOW)
            else $error("wrap while stopped");
    a_irq_masked:
        assert property (!irq_en && !$past(irq_en) |-> !IRQ) else $error("masked irq high");
    // the irq output lags a clear by one cycle, so a clear one cycle back excuses a drop
    a_irq_hold:
        assert property (IRQ && !clr_wr && !$past(clr_wr) |=> IRQ)
            else $error("irq dropped uncleared");
    a_urs_noflag:
        assert property (quiet && $past(quiet) && $past(quiet, 2) && !ien_wr && !$past(ien_wr)
                         |=> !$rose(IRQ))
            else $error("irq from silent update");
    c_ovf_update: cover property (UPDATE_EVENT && OVERFLOW);
    c_sw_update: cover property (UPDATE_EVENT && !OVERFLOW);
    c_irq_rise: cover property ($rose(IRQ));
endmodule
bind tbu_time_base tbu_time_base_monitor u_monitor (
    .SYS_CLK(SYS_CLK), .RESETN(RESETN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .UPDATE_EVENT(UPDATE_EVENT), .OVERFLOW(OVERFLOW), .IRQ(IRQ));
`default_nettype wire

// *** verification/tb.sv ***
/* register-level testbench of the time base.
   assumes the design files and the monitor are compiled before it. */
`timescale 1ns/1ns
`default_nettype none
`include "tbu_cfg.svh"
module tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic        wr_s = 1'b0;
    logic        rd_s = 1'b0;
    logic [31:0] rdata;
    logic        upd, ovf, irq;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0, last = 0, gap = 0, n_ovf = 0, n_upd = 0, u = 0;
    tbu_time_base dut (.SYS_CLK(clk), .RESETN(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr_s), .REG_RD(rd_s), .REG_RDATA(rdata), .UPDATE_EVENT(upd),
        .OVERFLOW(ovf), .IRQ(irq));
    // 20 MHz clock
    always #25 clk = ~clk;
    // wrap spacing and update tally
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (ovf === 1'b1) begin
            gap   <= cyc - last;
            last  <= cyc;
            n_ovf <= n_ovf + 1;
        end
        if (upd === 1'b1) begin
            n_upd <= n_upd + 1;
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_s  <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(rdata, e);
    endtask
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // wait for the next wrap, bounded
    task wait_ovf();
        int s;
        s = n_ovf;
        for (int i = 0; i < 100 && n_ovf == s; i++) step(1);
        if (n_ovf == s) chk(32'h0, 32'h1);
    endtask
    task complete_run();
        if (n_errors == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // hang guard, far beyond the few hundred cycles needed
    initial begin
        #(50 * 5000);
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 10; a++) begin
            rd(a == 9 ? 4'hf : 4'(a), 4'(a) == `TBU_OFS_RELOAD ? `TBU_RELOAD_RESET : 32'h0);
        end
        wr(`TBU_OFS_PRESCALE, 32'h12345);
        rd(`TBU_OFS_PRESCALE, 32'h2345);
        wr(4'hf, 32'h5a);
        rd(4'hf, 32'h0);
        wr(`TBU_OFS_PRESCALE, 32'h0);
        wr(`TBU_OFS_RELOAD, 32'h4);
        wr(`TBU_OFS_IRQ_ENABLE, 32'h1);
        wr(`TBU_OFS_CONTROL_ONE, 32'h1);
        wait_ovf();
        wait_ovf();
        chk(gap, 5);
        chk({31'h0, irq}, 32'h1);
        wr(`TBU_OFS_PRESCALE, 32'h2);
        rd(`TBU_OFS_STATUS_FLAGS, 32'h1);
        wait_ovf();
        chk(gap, 5);
        wait_ovf();
        chk(gap, 15);
        wr(`TBU_OFS_CONTROL_ONE, 32'h81);
        wr(`TBU_OFS_RELOAD, 32'h9);
        wait_ovf();
        chk(gap, 15);
        wait_ovf();
        chk(gap, 30);
        wr(`TBU_OFS_REPEAT, 32'h2);
        wait_ovf();
        u = n_upd;
        repeat (3) wait_ovf();
        chk(n_upd - u, 1);
        wr(`TBU_OFS_CONTROL_ONE, 32'h3);
        wr(`TBU_OFS_PRESCALE, 32'h0);
        u = n_upd;
        repeat (3) wait_ovf();
        chk(gap, 30);
        wr(`TBU_OFS_EVENT_GEN, 32'h1);
        wr(`TBU_OFS_IRQ_CLEAR, 32'h1);
        step(2);
        chk(n_upd - u, 0);
        chk({31'h0, irq}, 32'h0);
        wr(`TBU_OFS_CONTROL_ONE, 32'h0);
        step(4);
        u = n_upd;
        wr(`TBU_OFS_EVENT_GEN, 32'h1);
        step(3);
        chk(n_upd - u, 1);
        chk({31'h0, irq}, 32'h1);
        wr(`TBU_OFS_IRQ_ENABLE, 32'h0);
        step(2);
        chk({31'h0, irq}, 32'h0);
        wr(`TBU_OFS_IRQ_ENABLE, 32'h1);
        wr(`TBU_OFS_CONTROL_ONE, 32'h1);
        wait_ovf();
        wait_ovf();
        chk(gap, 10);
        wr(`TBU_OFS_CONTROL_ONE, 32'h4);
        wr(`TBU_OFS_STATUS_FLAGS, 32'h0);
        step(4);
        u = n_upd;
        wr(`TBU_OFS_EVENT_GEN, 32'h1);
        step(3);
        chk(n_upd - u, 1);
        chk({31'h0, irq}, 32'h0);
        rd(`TBU_OFS_STATUS_FLAGS, 32'h0);
        wr(`TBU_OFS_COUNT_VALUE, 32'h3);
        rd(`TBU_OFS_COUNT_VALUE, 32'h3);
        step(5);
        rd(`TBU_OFS_COUNT_VALUE, 32'h3);
        complete_run();
    end
endmodule
`default_nettype wire
